/* File: sbd_pkg.sv */
// Purpose: shared types and constants for the sensor bus slave command decoder
// Assumes: command and response words are 16 bits plus a 4-bit check field
// Notes: crc helper is shared by command checking and response building
`default_nettype none
package sbd_pkg;

	// command word layout, most significant field first
	typedef struct packed {
		logic [7:0] data;
		logic [3:0] addr;
		logic [3:0] code;
	} sbd_cmd_t;

	// one long word on the bus with its check field
	typedef struct packed {
		logic [15:0] word;
		logic [3:0] crc;
	} sbd_frame_t;

	// response slot tracking
	typedef enum logic [1:0] {
		RS_IDLE = 2'b01,
		RS_PEND = 2'b10
	} sbd_rsp_state_t;

	// command codes
	localparam logic [3:0] CMD_INIT = 4'h0;
	localparam logic [3:0] CMD_STATUS = 4'h1;
	localparam logic [3:0] CMD_AN0 = 4'h2;
	localparam logic [3:0] CMD_IOCTL = 4'h3;
	localparam logic [3:0] CMD_ID = 4'h4;
	localparam logic [3:0] CMD_AN1 = 4'h5;
	localparam logic [3:0] CMD_CLEAR = 4'h7;
	localparam logic [3:0] CMD_FMT = 4'ha;

	// node addressing
	localparam logic [3:0] ADDR_GLOBAL = 4'h0;
	localparam logic [3:0] NODE_RST = 4'h0;

	// data bit positions
	localparam int BIT_HS = 6;
	localparam int BIT_LS = 5;
	localparam int BIT_OD = 4;
	localparam int BIT_RW = 7;

	// format register pointers and values
	localparam logic [2:0] FREG_POLY = 3'h0;
	localparam logic [2:0] FREG_SEED = 3'h2;
	localparam logic [2:0] FREG_SWLEN = 3'h5;
	localparam logic [2:0] FREG_SEL = 3'h7;
	localparam logic [3:0] POLY_STD = 4'h1;
	localparam logic [3:0] SEED_STD = 4'ha;
	localparam logic [3:0] SWLEN_STD = 4'h8;
	localparam logic [3:0] SWLEN_ALT = 4'ha;
	localparam logic [3:0] SEL_STD = 4'h0;
	localparam logic [3:0] SEL_ENH = 4'hf;

	// register bus byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_ADC0 = 4'h8;
	localparam logic [3:0] OFF_ADC1 = 4'hc;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int CTRL_CRC_EN = 0;
	localparam int ADC_W = 10;

	// check field over a 16-bit word, msb first
	function automatic logic [3:0] crc4(input logic [15:0] d, input logic [3:0] poly, input logic [3:0] seed);
		logic [3:0] c;
		logic fb;
		c = seed;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			fb = c[3] ^ d[i];
			c = {c[2:0], 1'b0} ^ (fb ? poly : 4'h0);
		end
		return c;
	endfunction

endpackage
`default_nettype wire

/* File: sbd_cmd_decoder.sv */
// Purpose: decode sensor bus commands and build long-word responses
// Assumes: one frame per cmd_valid_i pulse; msg_start_i marks each new bus message
// Notes: software supplies conversion results and reads status over Avalon-MM
//
// Overview of operation
// R1: every frame carries a four-bit check field
// R2: init command closes high switch on bit
// R3: init command closes low switch independently
// R4: init command adopts data low nibble address
// R5: dither bit zero disables, one enables
// R6: io control sets pin directions, one output
// R7: output pins driven to their level bits
// R8: format command writes when top bit set
// R9: bits six to four pick format register
// R10: low data nibble is format write value
// R11: response starts with node address, zeros
// R12: init and status report switch states
// R13: status returns sampled pin levels
// R14: id response returns version and flag
// R15: format response echoes read or write
// R16: format response returns register pointer
// R17: format response returns register contents
// R18: io response echoes levels and directions
// R19: don't-care command bits are ignored
// R20: analog responses carry upper eight result bits
// R21: clear and reserved codes get no response
// R22: act on own or global address only
// R23: response goes out in next message
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module sbd_cmd_decoder #(
	parameter logic [3:0] VERSION = 4'h1, // arbitrary value
	parameter logic ID_FLAG = 1'b0 // arbitrary value
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic msg_start_i,
	input wire logic cmd_valid_i,
	input wire sbd_pkg::sbd_frame_t cmd_frame_i,
	input wire logic [2:0] io_in_i,
	output logic rsp_valid_o,
	output sbd_pkg::sbd_frame_t rsp_frame_o,
	output logic hs_switch_o,
	output logic ls_switch_o,
	output logic dither_o,
	output logic [2:0] io_out_o,
	output logic [2:0] io_oe_o,
	output logic enhanced_o,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta_ff;
	logic rst_n_ff;

	// two-stage release so downstream logic leaves reset on a clean edge
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state
	localparam int ADC_W = sbd_pkg::ADC_W;
	logic [3:0] node_ff;
	logic hs_ff;
	logic ls_ff;
	logic od_ff;
	logic [2:0] lvl_ff;
	logic [2:0] dir_ff;
	logic [2:0] io_smp_ff;
	logic [3:0] poly_ff;
	logic [3:0] seed_ff;
	logic [3:0] swlen_ff;
	logic [3:0] sel_ff;
	logic [31:0] ctrl_ff;
	logic [ADC_W-1:0] adc0_ff;
	logic [ADC_W-1:0] adc1_ff;
	logic [7:0] crc_err_ff;
	sbd_pkg::sbd_rsp_state_t rs_ff;
	logic [3:0] pend_code_ff;
	logic [7:0] pend_data_ff;
	logic rsp_valid_ff;
	sbd_pkg::sbd_frame_t rsp_frame_ff;
	logic wreq_ff;
	logic [31:0] rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// command decode
	sbd_pkg::sbd_cmd_t cmd;
	logic enh;
	logic [3:0] act_poly;
	logic [3:0] act_seed;
	logic crc_ok;
	logic take;
	logic speak;
	logic is_clear;
	logic fmt_wr;
	logic [2:0] fptr;
	logic [3:0] fval;

	// only the fields each code uses are looked at, the rest are don't-care
	assign cmd = sbd_pkg::sbd_cmd_t'(cmd_frame_i.word); // R19
	assign enh = (sel_ff == sbd_pkg::SEL_ENH);
	assign act_poly = enh ? poly_ff : sbd_pkg::POLY_STD;
	assign act_seed = enh ? seed_ff : sbd_pkg::SEED_STD;
	// a bad check field drops the word before any side effect
	assign crc_ok = !ctrl_ff[sbd_pkg::CTRL_CRC_EN]
		|| (sbd_pkg::crc4(cmd_frame_i.word, act_poly, act_seed) == cmd_frame_i.crc); // R1
	assign take = cmd_valid_i && crc_ok
		&& ((cmd.addr == node_ff) || (cmd.addr == sbd_pkg::ADDR_GLOBAL)); // R22
	assign is_clear = take && (cmd.code == sbd_pkg::CMD_CLEAR);
	assign fmt_wr = take && (cmd.code == sbd_pkg::CMD_FMT) && cmd.data[sbd_pkg::BIT_RW]; // R8
	assign fptr = cmd.data[6:4]; // R9
	assign fval = cmd.data[3:0]; // R10

	// global address acts silently; clear and reserved codes never answer
	always_comb begin
		speak = 1'b0;
		if (take && (cmd.addr != sbd_pkg::ADDR_GLOBAL)) begin // R22
			case (cmd.code)
				sbd_pkg::CMD_INIT, sbd_pkg::CMD_STATUS, sbd_pkg::CMD_AN0, sbd_pkg::CMD_IOCTL,
				sbd_pkg::CMD_ID, sbd_pkg::CMD_AN1, sbd_pkg::CMD_FMT: speak = 1'b1;
				default: speak = 1'b0; // R21
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// node, switches, dither
	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			node_ff <= sbd_pkg::NODE_RST;
			hs_ff <= 1'b0;
			ls_ff <= 1'b0;
			od_ff <= 1'b0;
		end else if (is_clear) begin
			node_ff <= sbd_pkg::NODE_RST;
			hs_ff <= 1'b0;
			ls_ff <= 1'b0;
			od_ff <= 1'b0;
		end else if (take && (cmd.code == sbd_pkg::CMD_INIT)) begin
			hs_ff <= cmd.data[sbd_pkg::BIT_HS]; // R2
			ls_ff <= cmd.data[sbd_pkg::BIT_LS]; // R3
			od_ff <= cmd.data[sbd_pkg::BIT_OD]; // R5
			node_ff <= cmd.data[3:0]; // R4
		end
	end

	// general pins: direction and level; inputs are taken as synchronous
	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			lvl_ff <= 3'h0;
			dir_ff <= 3'h0;
			io_smp_ff <= 3'h0;
		end else begin
			io_smp_ff <= io_in_i;
			if (is_clear) begin
				lvl_ff <= 3'h0;
				dir_ff <= 3'h0;
			end else if (take && (cmd.code == sbd_pkg::CMD_IOCTL)) begin
				dir_ff <= cmd.data[2:0]; // R6
				lvl_ff <= cmd.data[6:4]; // R7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// format registers; once enhanced, only a return to standard is accepted
	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			poly_ff <= sbd_pkg::POLY_STD;
			seed_ff <= sbd_pkg::SEED_STD;
			swlen_ff <= sbd_pkg::SWLEN_STD;
			sel_ff <= sbd_pkg::SEL_STD;
		end else if (is_clear) begin
			poly_ff <= sbd_pkg::POLY_STD;
			seed_ff <= sbd_pkg::SEED_STD;
			swlen_ff <= sbd_pkg::SWLEN_STD;
			sel_ff <= sbd_pkg::SEL_STD;
		end else if (fmt_wr) begin // R8
			case (fptr) // R9
				sbd_pkg::FREG_POLY: if (!enh) poly_ff <= fval; // R10
				sbd_pkg::FREG_SEED: if (!enh) seed_ff <= fval;
				sbd_pkg::FREG_SWLEN: begin
					if (!enh && ((fval == sbd_pkg::SWLEN_STD) || (fval == sbd_pkg::SWLEN_ALT))) swlen_ff <= fval;
				end
				sbd_pkg::FREG_SEL: begin
					// all four bits in one write, guards against a corrupted word
					if (!enh && (fval == sbd_pkg::SEL_ENH)) sel_ff <= sbd_pkg::SEL_ENH;
					else if (enh && (fval == sbd_pkg::SEL_STD)) sel_ff <= sbd_pkg::SEL_STD;
				end
				default: ; // reserved slots hold nothing
			endcase
		end
	end

	// format register readback, reserved slots read zero
	function automatic logic [3:0] freg(input logic [2:0] p, input logic [3:0] po, input logic [3:0] se,
		input logic [3:0] sw, input logic [3:0] sl);
		case (p)
			sbd_pkg::FREG_POLY: return po;
			sbd_pkg::FREG_SEED: return se;
			sbd_pkg::FREG_SWLEN: return sw;
			sbd_pkg::FREG_SEL: return sl;
			default: return 4'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// response builder, evaluated from current state when the slot opens
	logic [15:0] rsp_word;
	logic [7:0] rsp_data;

	always_comb begin
		rsp_data = 8'h00;
		case (pend_code_ff)
			sbd_pkg::CMD_INIT: rsp_data = {1'b0, hs_ff, ls_ff, 1'b0, node_ff}; // R12
			sbd_pkg::CMD_STATUS: rsp_data = {1'b0, hs_ff, ls_ff, 2'b00, io_smp_ff}; // R13
			sbd_pkg::CMD_AN0: rsp_data = adc0_ff[ADC_W-1:ADC_W-8]; // R20
			sbd_pkg::CMD_AN1: rsp_data = adc1_ff[ADC_W-1:ADC_W-8]; // R20
			sbd_pkg::CMD_IOCTL: rsp_data = {1'b0, lvl_ff, 1'b0, dir_ff}; // R18
			sbd_pkg::CMD_ID: rsp_data = {VERSION, 3'b000, ID_FLAG}; // R14
			sbd_pkg::CMD_FMT: rsp_data = {pend_data_ff[sbd_pkg::BIT_RW], pend_data_ff[6:4], // R15 R16
				freg(pend_data_ff[6:4], poly_ff, seed_ff, swlen_ff, sel_ff)}; // R17
			default: rsp_data = 8'h00;
		endcase
		rsp_word = {node_ff, 4'h0, rsp_data}; // R11
	end

	// a response waits for the next message and is sent once
	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rs_ff <= sbd_pkg::RS_IDLE;
			pend_code_ff <= 4'h0;
			pend_data_ff <= 8'h00;
			rsp_valid_ff <= 1'b0;
			rsp_frame_ff <= '0;
		end else begin
			rsp_valid_ff <= 1'b0;
			case (rs_ff)
				sbd_pkg::RS_IDLE: begin
					if (speak) begin
						rs_ff <= sbd_pkg::RS_PEND;
						pend_code_ff <= cmd.code;
						pend_data_ff <= cmd.data;
					end
				end
				sbd_pkg::RS_PEND: begin
					if (msg_start_i) begin // R23
						rs_ff <= sbd_pkg::RS_IDLE;
						rsp_valid_ff <= 1'b1;
						rsp_frame_ff.word <= rsp_word;
						rsp_frame_ff.crc <= sbd_pkg::crc4(rsp_word, act_poly, act_seed); // R1
					end else if (take && !speak) begin
						rs_ff <= sbd_pkg::RS_IDLE; // R22
					end else if (speak) begin
						pend_code_ff <= cmd.code;
						pend_data_ff <= cmd.data;
					end
				end
				default: rs_ff <= sbd_pkg::RS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then the access completes
	logic avs_req;
	logic avs_wr_now;
	logic [31:0] rd_mux;

	assign avs_req = avs_read_i || avs_write_i;
	assign avs_wr_now = avs_write_i && !wreq_ff;

	// byte-lane merge for register writes
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// unmapped offsets read zero and swallow writes
	always_comb begin
		rd_mux = 32'h0;
		case (avs_address_i)
			sbd_pkg::OFF_CTRL: rd_mux = ctrl_ff;
			sbd_pkg::OFF_STATUS: rd_mux = {13'h0, io_smp_ff, crc_err_ff, sel_ff[3], od_ff, ls_ff, hs_ff, node_ff};
			sbd_pkg::OFF_ADC0: rd_mux = {22'h0, adc0_ff};
			sbd_pkg::OFF_ADC1: rd_mux = {22'h0, adc1_ff};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			wreq_ff <= 1'b1;
			rdata_ff <= 32'h0;
		end else begin
			wreq_ff <= !(avs_req && wreq_ff);
			if (avs_req && wreq_ff) rdata_ff <= rd_mux;
		end
	end

	// writable registers take effect on the edge after the wait ends, when the access completes
	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ctrl_ff <= sbd_pkg::CTRL_RST;
			adc0_ff <= '0;
			adc1_ff <= '0;
		end else if (avs_wr_now) begin
			case (avs_address_i)
				sbd_pkg::OFF_CTRL: ctrl_ff <= be_merge(ctrl_ff, avs_writedata_i, avs_byteenable_i) & 32'h0000_0001;
				sbd_pkg::OFF_ADC0: adc0_ff <= ADC_W'(be_merge({22'h0, adc0_ff}, avs_writedata_i, avs_byteenable_i));
				sbd_pkg::OFF_ADC1: adc1_ff <= ADC_W'(be_merge({22'h0, adc1_ff}, avs_writedata_i, avs_byteenable_i));
				default: ;
			endcase
		end
	end

	// saturating count of dropped words, software sees link quality
	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			crc_err_ff <= 8'h00;
		end else if (cmd_valid_i && !crc_ok && (crc_err_ff != 8'hff)) begin
			crc_err_ff <= crc_err_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign rsp_valid_o = rsp_valid_ff;
	assign rsp_frame_o = rsp_frame_ff;
	assign hs_switch_o = hs_ff;
	assign ls_switch_o = ls_ff;
	assign dither_o = od_ff;
	assign io_out_o = lvl_ff;
	assign io_oe_o = dir_ff;
	assign enhanced_o = sel_ff[3];
	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wreq_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_init_switches: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R2 R3 R5
		take && (cmd.code == sbd_pkg::CMD_INIT) |=> (hs_switch_o == $past(cmd.data[6]))
			&& (ls_switch_o == $past(cmd.data[5])) && (dither_o == $past(cmd.data[4])))
		else $error("init did not set switches or dither");

	a_node_adopt: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R4
		take && (cmd.code == sbd_pkg::CMD_INIT) |=> node_ff == $past(cmd.data[3:0]))
		else $error("node address not adopted");

	a_io_config: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R6 R7
		take && (cmd.code == sbd_pkg::CMD_IOCTL) |=> (io_oe_o == $past(cmd.data[2:0]))
			&& (io_out_o == $past(cmd.data[6:4])))
		else $error("pin direction or level wrong");

	a_fmt_read_only: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R8
		take && (cmd.code == sbd_pkg::CMD_FMT) && !cmd.data[7] |=> $stable(poly_ff) && $stable(seed_ff)
			&& $stable(swlen_ff) && $stable(sel_ff))
		else $error("format read changed a register");

	a_crc_reject: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R1
		cmd_valid_i && !crc_ok && (rs_ff == sbd_pkg::RS_IDLE) && !msg_start_i |=> $stable(node_ff)
			&& (rs_ff == sbd_pkg::RS_IDLE))
		else $error("bad check field was acted on");

	a_rsp_header: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R11
		rsp_valid_o |-> rsp_frame_o.word[11:8] == 4'h0)
		else $error("response header bits not zero");

	a_rsp_next_msg: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R23
		rsp_valid_o |-> $past(msg_start_i) && ($past(rs_ff) == sbd_pkg::RS_PEND) ##1 !rsp_valid_o)
		else $error("response outside the next message slot");

	a_global_silent: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R22
		take && (cmd.addr == sbd_pkg::ADDR_GLOBAL) && !msg_start_i |=> rs_ff == sbd_pkg::RS_IDLE ##1 !rsp_valid_o)
		else $error("global command produced a response");

	a_no_answer: assert property (@(posedge clock_i) disable iff (!rst_n_ff) // R21
		take && ((cmd.code == sbd_pkg::CMD_CLEAR) || (cmd.code == 4'h6)) && (rs_ff == sbd_pkg::RS_IDLE)
			|=> rs_ff == sbd_pkg::RS_IDLE)
		else $error("clear or reserved code queued a response");

	a_bus_wait: assert property (@(posedge clock_i) disable iff (!rst_n_ff)
		avs_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus wait not exactly one cycle");

endmodule
`default_nettype wire

/* File: sbd_master_model.sv */
// Purpose: behavioural bus master that sends command frames and opens response slots
// Assumes: standard check polynomial and seed; enhanced mode changes are not followed here
// Notes: the command line shows the inverted last word while idle so stale data never matches
`timescale 1ns/10ps
`default_nettype none
module sbd_master_model (
	input wire logic clock_i,
	output logic msg_start_o,
	output logic cmd_valid_o,
	output sbd_pkg::sbd_frame_t cmd_frame_o,
	input wire logic rsp_valid_i,
	input wire sbd_pkg::sbd_frame_t rsp_frame_i
);
	////////////////////////////////////////////////////////////////////////////////
	// own check field, msb first, kept apart from the design's helper
	function automatic logic [3:0] chk4(input logic [15:0] w);
		logic [3:0] c;
		logic fb;
		c = sbd_pkg::SEED_STD;
		for (int i = 15; i >= 0; i--) begin
			fb = c[3] ^ w[i];
			c = {c[2:0], 1'b0} ^ (fb ? sbd_pkg::POLY_STD : 4'h0);
		end
		return c;
	endfunction

	// idle levels at time zero
	initial begin
		msg_start_o = 1'b0;
		cmd_valid_o = 1'b0;
		cmd_frame_o = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one command frame; bad flips the low bit of the check field to provoke a refusal
	task automatic send(input logic [3:0] code, input logic [3:0] addr, input logic [7:0] data, input logic bad);
		logic [15:0] w;
		w = {data, addr, code};
		@(posedge clock_i);
		cmd_valid_o <= 1'b1;
		cmd_frame_o <= {w, chk4(w) ^ {3'h0, bad}};
		@(posedge clock_i);
		cmd_valid_o <= 1'b0;
		cmd_frame_o <= ~{w, chk4(w)};
	endtask

	// next message: start pulse, then read what comes back; a long pulse marks saw unknown
	task automatic slot(output logic saw, output logic [15:0] word, output logic [3:0] cs, output logic [3:0] ce);
		@(posedge clock_i);
		msg_start_o <= 1'b1;
		@(posedge clock_i);
		msg_start_o <= 1'b0;
		#1;
		saw = rsp_valid_i;
		word = rsp_frame_i.word;
		cs = rsp_frame_i.crc;
		ce = chk4(rsp_frame_i.word);
		@(posedge clock_i);
		#1;
		if (rsp_valid_i !== 1'b0) begin
			saw = 1'bx;
		end
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for the sensor bus command decoder
// Assumes: byte enables tied to all lanes; version and flag set to arbitrary test values
// Notes: expected words are built here from the field layout, never read back from the design
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic clk, rstn, msg_start, cmd_valid, rsp_valid, hs, ls, dither, enh;
	logic avs_read, avs_write, avs_wait;
	logic [2:0] io_in, io_out, io_oe;
	logic [3:0] avs_addr, node;
	logic [31:0] avs_wdata, avs_rdata, rd;
	sbd_pkg::sbd_frame_t cmd_frame, rsp_frame;
	int error_cnt = 0;
	int total_checks = 0;

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	sbd_cmd_decoder #(.VERSION(4'h3), .ID_FLAG(1'b1)) dut (
		.clock_i(clk), .rstn_i(rstn), .msg_start_i(msg_start), .cmd_valid_i(cmd_valid),
		.cmd_frame_i(cmd_frame), .io_in_i(io_in), .rsp_valid_o(rsp_valid), .rsp_frame_o(rsp_frame),
		.hs_switch_o(hs), .ls_switch_o(ls), .dither_o(dither), .io_out_o(io_out), .io_oe_o(io_oe),
		.enhanced_o(enh), .avs_address_i(avs_addr), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(avs_rdata),
		.avs_waitrequest_o(avs_wait)
	);
	sbd_master_model mdl (
		.clock_i(clk), .msg_start_o(msg_start), .cmd_valid_o(cmd_valid), .cmd_frame_o(cmd_frame),
		.rsp_valid_i(rsp_valid), .rsp_frame_i(rsp_frame)
	);

	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one Avalon-MM transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_addr <= a;
		avs_wdata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (avs_wait !== 1'b0 && n < 20);
		q = avs_rdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_wait !== 1'b0) begin
			error_cnt++;
			$display("unexpected bus wait expected done seen timeout");
			summarize();
		end
	endtask

	// command, then the following slot; checks presence, word and check field
	task automatic rsp(input logic [3:0] code, input logic [3:0] a, input logic [7:0] d, input logic es,
		input logic [7:0] ed);
		logic saw;
		logic [15:0] w;
		logic [3:0] cs, ce;
		mdl.send(code, a, d, 1'b0);
		mdl.slot(saw, w, cs, ce);
		`CHK("rsp valid", es, saw)
		if (es) begin
			`CHK("rsp word", {node, 4'h0, ed}, w)
			`CHK("rsp crc", ce, cs)
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rstn = 1'b0;
		io_in = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_addr = 4'h0;
		avs_wdata = 32'h0;
		node = 4'h0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("idle outputs", 10'h001, {hs, ls, dither, io_out, io_oe, avs_wait})
		bus(1'b0, sbd_pkg::OFF_CTRL, 32'h0, rd);
		`CHK("ctrl reset", 32'h0000_0001, rd)
		bus(1'b0, sbd_pkg::OFF_STATUS, 32'h0, rd);
		`CHK("status reset", 32'h0, rd)
		// global init acts silently
		rsp(4'h0, 4'h0, 8'h54, 1'b0, 8'h0);
		node = 4'h4;
		`CHK("init switches", 3'b101, {hs, ls, dither})
		// own address, don't-care bit set, switches swapped
		rsp(4'h0, 4'h4, 8'ha4, 1'b1, 8'h24);
		`CHK("init switches", 3'b010, {hs, ls, dither})
		rsp(4'h3, 4'h4, 8'hdf, 1'b1, 8'h57);
		`CHK("pins", 6'o57, {io_out, io_oe})
		rsp(4'h3, 4'h4, 8'h32, 1'b1, 8'h32);
		`CHK("pins", 6'o32, {io_out, io_oe})
		@(posedge clk) io_in <= 3'b101;
		rsp(4'h1, 4'h4, 8'hff, 1'b1, 8'h25);
		bus(1'b1, sbd_pkg::OFF_ADC0, 32'h0000_02ad, rd);
		rsp(4'h2, 4'h4, 8'h00, 1'b1, 8'hab);
		bus(1'b1, sbd_pkg::OFF_ADC1, 32'h0000_0155, rd);
		rsp(4'h5, 4'h4, 8'h00, 1'b1, 8'h55);
		rsp(4'h4, 4'h4, 8'h00, 1'b1, 8'h31);
		// format registers: read, write, refused value, reserved place, read back
		rsp(4'ha, 4'h4, 8'h0f, 1'b1, 8'h01);
		rsp(4'ha, 4'h4, 8'hda, 1'b1, 8'hda);
		rsp(4'ha, 4'h4, 8'hd3, 1'b1, 8'hda);
		rsp(4'ha, 4'h4, 8'h97, 1'b1, 8'h90);
		rsp(4'ha, 4'h4, 8'h50, 1'b1, 8'h5a);
		rsp(4'ha, 4'h4, 8'hff, 1'b1, 8'hff);
		`CHK("enhanced", 1'b1, enh)
		rsp(4'ha, 4'h4, 8'hf0, 1'b1, 8'hf0);
		`CHK("enhanced", 1'b0, enh)
		rsp(4'h1, 4'h9, 8'h00, 1'b0, 8'h0);
		for (int c = 6; c < 16; c++) begin
			if (c != 7 && c != 10) begin
				rsp(c[3:0], 4'h4, 8'h00, 1'b0, 8'h0);
			end
		end
		// refused check field bumps the error count
		mdl.send(4'h1, 4'h4, 8'h00, 1'b1);
		rsp(4'h4, 4'h0, 8'h00, 1'b0, 8'h0);
		bus(1'b0, sbd_pkg::OFF_STATUS, 32'h0, rd);
		`CHK("crc errors", 8'h01, rd[15:8])
		// check switched off: a bad check field is acted on
		bus(1'b1, sbd_pkg::OFF_CTRL, 32'h0, rd);
		bus(1'b0, sbd_pkg::OFF_CTRL, 32'h0, rd);
		`CHK("ctrl off", 32'h0, rd)
		mdl.send(4'h3, 4'h4, 8'h07, 1'b1);
		#1;
		`CHK("check off pins", 6'o07, {io_out, io_oe})
		rsp(4'h7, 4'h4, 8'h00, 1'b0, 8'h0);
		`CHK("cleared", 9'h0, {hs, ls, dither, io_out, io_oe})
		bus(1'b0, sbd_pkg::OFF_STATUS, 32'h0, rd);
		`CHK("cleared status", 11'h500, {rd[18:16], rd[7:0]})
		// unmapped place reads zero and drops writes
		bus(1'b1, 4'h2, 32'hffff_ffff, rd);
		bus(1'b0, 4'h2, 32'h0, rd);
		`CHK("unmapped", 32'h0, rd)
		summarize();
	end
endmodule
`default_nettype wire
